//--- hw/dlc_pkg.sv
package dlc_pkg;
   // lane select codes and lane count
   localparam logic [1:0] DLC_LS_ONE    = 2'h0;
   localparam logic [1:0] DLC_LS_FOUR   = 2'h3;
   localparam int         DLC_LANES     = 4;
   // escape entry commands, leftmost bit goes first on the wire
   localparam logic [7:0] DLC_ESC_LPDT  = 8'hE1;
   localparam logic [7:0] DLC_ESC_ULPS  = 8'h1E;
   localparam logic [7:0] DLC_ESC_RAR   = 8'h62;
   localparam logic [7:0] DLC_ESC_TE    = 8'h5D;
   localparam logic [7:0] DLC_ESC_ACK   = 8'h21;
   localparam int         DLC_CMD_BITS  = 8;
   // hs leader 011101, leftmost first
   localparam logic [5:0] DLC_LEADER    = 6'h1D;
   localparam int         DLC_LEAD_BITS = 6;
   // packet data types used by the scheduler
   localparam logic [5:0] DLC_DT_GEN_LW = 6'h29;
   localparam logic [5:0] DLC_DT_DCS_LW = 6'h39;
   localparam logic [5:0] DLC_DT_BLANK  = 6'h19;
   localparam logic [5:0] DLC_DT_RGB24  = 6'h3E;
   // reset values
   localparam logic [7:0] DLC_CNT_RST   = 8'h00;
   localparam logic [1:0] DLC_VC_RST    = 2'h0;
   localparam logic [5:0] DLC_DT_RST    = 6'h00;

   typedef enum logic [1:0] {DLC_OP_HS, DLC_OP_ESC, DLC_OP_TA} dlc_op_e;
   typedef enum logic [1:0] {DLC_E_ULPS, DLC_E_RAR, DLC_E_TE, DLC_E_ACK} dlc_esc_e;

   // one lane's line state: hs flag, dp level, dn level
   typedef struct packed {
      logic hs;
      logic dp;
      logic dn;
   } dlc_lane_t;

   // command word, held stable by sys side while its request is up
   typedef struct packed {
      dlc_op_e    op;
      logic [7:0] esc_cmd;
      logic [3:0] lane_on;
      logic [7:0] len;
   } dlc_cmd_t;

   localparam dlc_lane_t DLC_LP11 = '{hs: 1'b0, dp: 1'b1, dn: 1'b1};
endpackage

//--- hw/dlc_top.sv
`timescale 1ns/1ps
`default_nettype none
module dlc_top
   import dlc_pkg::*;
(
   input  wire logic              clk_sys,
   input  wire logic              reset_n,
   input  wire logic              clk_link,
   input  wire logic [1:0]        lane_count_select,
   input  wire logic              nonvideo_lowpower_select,
   input  wire logic              blanking_lowpower_select,
   input  wire logic              burst_mode,
   input  wire logic [1:0]        virtual_channel_reg,
   input  wire logic              hblank,
   input  wire logic              vblank,
   input  wire logic              vid_valid,
   input  wire logic [7:0]        vid_len,
   input  wire logic              nv_valid,
   input  wire logic              nv_dcs,
   input  wire logic [7:0]        nv_len,
   input  wire logic              esc_valid,
   input  wire dlc_esc_e          esc_sel,
   input  wire logic              ta_valid,
   input  wire logic              link_tx_bit,
   output logic                   link_bit_rd,
   output logic                   vid_taken,
   output logic                   nv_taken,
   output logic                   esc_taken,
   output logic                   ta_taken,
   output logic [5:0]             pkt_dt,
   output logic [1:0]             pkt_vc,
   output logic                   busy,
   output dlc_lane_t              clock_lane,
   output dlc_lane_t [3:0]        data_lane
);

   // ---------------- sys domain: blanking scheduler ----------------
   typedef enum logic [1:0] {S_IDLE, S_WAIT_ACK, S_WAIT_REL} dlc_sstate_e;

   dlc_sstate_e sst_ff, nxt_sst;
   dlc_cmd_t    cmd_ff, nxt_cmd;
   logic        req_ff, ack_s1_ff, ack_s2_ff, blk_done_ff;
   logic        ack_ff; // link side done flag, driven in the link domain below
   logic [5:0]  dt_ff, nxt_dt;
   logic [1:0]  vc_ff;
   logic [3:0]  take_ff, nxt_take;

   // lane count decode: lane 0 always, upward from there
   function automatic logic [3:0] lanes_of(input logic [1:0] ls);
      lanes_of = 4'hF >> (2'h3 - ls);
   endfunction

   function automatic logic [7:0] esc_code(input dlc_esc_e s);
      logic [7:0] c;
      c = DLC_ESC_ULPS;
      if (s == DLC_E_RAR) c = DLC_ESC_RAR;
      if (s == DLC_E_TE) c = DLC_ESC_TE;
      if (s == DLC_E_ACK) c = DLC_ESC_ACK;
      return c;
   endfunction

   // which work may go now; non-video outranks blanking fill and escapes
   wire blank    = hblank | vblank;
   wire nv_win   = burst_mode ? blank : vblank;
   wire nv_go    = nv_valid & nv_win;
   wire hs_fill  = ~nonvideo_lowpower_select & ~blanking_lowpower_select & ~burst_mode;
   wire blk_go   = blank & hs_fill & ~blk_done_ff & ~nv_go;
   wire esc_go   = esc_valid & blank & ~nv_go & ~blk_go;
   wire ta_go    = ta_valid & blank & ~nv_go & ~blk_go & ~esc_go;
   wire vid_go   = vid_valid & ~blank;
   wire any_go   = nv_go | blk_go | esc_go | ta_go | vid_go;
   wire acked    = ack_s2_ff;

   // command word chosen in idle, then frozen for the crossing
   always_comb
   begin
      nxt_sst  = sst_ff;
      nxt_cmd  = cmd_ff;
      nxt_dt   = dt_ff;
      nxt_take = 4'h0;
      unique case (sst_ff)
         S_IDLE:
            if (any_go)
            begin
               nxt_sst = S_WAIT_ACK;
               nxt_cmd.lane_on = lanes_of(lane_count_select);
               nxt_cmd.esc_cmd = DLC_ESC_LPDT;
               if (nv_go)
               begin
                  // lp data when nonvideo_lowpower_select is set, else hs burst and then back to stop
                  nxt_cmd.op  = nonvideo_lowpower_select ? DLC_OP_ESC : DLC_OP_HS;
                  nxt_cmd.len = nv_len;
                  nxt_dt      = nv_dcs ? DLC_DT_DCS_LW : DLC_DT_GEN_LW;
                  nxt_take[1] = 1'b1;
               end
               else if (blk_go)
               begin
                  nxt_cmd.op  = DLC_OP_HS;
                  nxt_cmd.len = vid_len;
                  nxt_dt      = DLC_DT_BLANK;
               end
               else if (esc_go)
               begin
                  nxt_cmd.op      = DLC_OP_ESC;
                  nxt_cmd.esc_cmd = esc_code(esc_sel);
                  nxt_cmd.len     = DLC_CNT_RST;
                  nxt_take[2]     = 1'b1;
               end
               else if (ta_go)
               begin
                  nxt_cmd.op  = DLC_OP_TA;
                  nxt_take[3] = 1'b1;
               end
               else
               begin
                  nxt_cmd.op  = DLC_OP_HS;
                  nxt_cmd.len = vid_len;
                  nxt_dt      = DLC_DT_RGB24;
                  nxt_take[0] = 1'b1;
               end
            end
         S_WAIT_ACK:
            if (acked)
               nxt_sst = S_WAIT_REL;
         S_WAIT_REL:
            if (!acked)
               nxt_sst = S_IDLE;
         default:
            nxt_sst = S_IDLE;
      endcase
   end

   always_ff @(posedge clk_sys or negedge reset_n)
   begin
      if (!reset_n)
      begin
         sst_ff  <= S_IDLE;
         cmd_ff  <= '0;
         dt_ff   <= DLC_DT_RST;
         take_ff <= 4'h0;
      end
      else
      begin
         sst_ff  <= nxt_sst;
         cmd_ff  <= nxt_cmd;
         dt_ff   <= nxt_dt;
         take_ff <= nxt_take;
      end
   end

   // request level and ack synchroniser; vc latched per packet
   always_ff @(posedge clk_sys or negedge reset_n)
   begin
      if (!reset_n)
      begin
         req_ff      <= 1'b0;
         ack_s1_ff   <= 1'b0;
         ack_s2_ff   <= 1'b0;
         blk_done_ff <= 1'b0;
         vc_ff       <= DLC_VC_RST;
      end
      else
      begin
         req_ff      <= (nxt_sst == S_WAIT_ACK);
         ack_s1_ff   <= ack_ff;
         ack_s2_ff   <= ack_s1_ff;
         blk_done_ff <= blank & (blk_done_ff | (sst_ff == S_IDLE & blk_go));
         if (sst_ff == S_IDLE && any_go)
            vc_ff <= virtual_channel_reg;
      end
   end

   assign vid_taken = take_ff[0];
   assign nv_taken  = take_ff[1];
   assign esc_taken = take_ff[2];
   assign ta_taken  = take_ff[3];
   assign pkt_dt    = dt_ff;
   assign pkt_vc    = vc_ff;
   assign busy      = (sst_ff != S_IDLE);

   // ---------------- link domain: lane sequencer ----------------
   typedef enum logic [4:0] {
      L_STOP, L_SOT01, L_SOT00, L_LEAD, L_PAY, L_EOT00, L_EOT10,
      L_TA01, L_TA00, L_TAHS0, L_E10, L_E00A, L_E01, L_E00B,
      L_EMARK, L_ESPACE, L_EX10, L_DONE
   } dlc_lstate_e;

   dlc_lstate_e lst_ff, nxt_lst;
   dlc_cmd_t    lcmd_ff;
   logic        req_s1_ff, req_s2_ff, ddr_ff;
   logic [7:0]  cnt_ff, nxt_cnt;
   dlc_lane_t   clane_ff;
   dlc_lane_t [3:0] dlane_ff;

   // cmd_ff is stable long before req reaches req_s2_ff, so it is read directly
   wire        start    = (lst_ff == L_STOP) & req_s2_ff;
   wire [8:0]  esc_bits = 9'(DLC_CMD_BITS) + 9'(lcmd_ff.len);
   wire [7:0]  cmd_idx  = 8'(DLC_CMD_BITS - 1) - cnt_ff;
   wire        cmd_bit  = lcmd_ff.esc_cmd[cmd_idx[2:0]];
   wire        in_cmd   = (cnt_ff < 8'(DLC_CMD_BITS));
   wire [7:0]  lead_idx = 8'(DLC_LEAD_BITS - 1) - cnt_ff;
   wire        lead_bit = DLC_LEADER[lead_idx[2:0]];
   wire        mark_bit = in_cmd ? cmd_bit : link_tx_bit;
   wire        hs_bit   = (lst_ff == L_LEAD) ? lead_bit : link_tx_bit;

   // line levels per state; hs drives dp=bit, dn=~bit
   function automatic dlc_lane_t lane_code(input dlc_lstate_e s, input logic hb, input logic mb);
      dlc_lane_t c;
      c = DLC_LP11;
      unique case (s)
         L_SOT01, L_TA01, L_E01:  c = '{hs: 1'b0, dp: 1'b0, dn: 1'b1};
         L_SOT00, L_EOT00, L_TA00, L_E00A, L_E00B, L_ESPACE:
                                  c = '{hs: 1'b0, dp: 1'b0, dn: 1'b0};
         L_EOT10, L_E10, L_EX10:  c = '{hs: 1'b0, dp: 1'b1, dn: 1'b0};
         L_LEAD, L_PAY:           c = '{hs: 1'b1, dp: hb, dn: ~hb};
         L_TAHS0:                 c = '{hs: 1'b1, dp: 1'b0, dn: 1'b1};
         L_EMARK:                 c = '{hs: 1'b0, dp: mb, dn: ~mb};
         L_STOP, L_DONE:          c = DLC_LP11;
      endcase
      return c;
   endfunction

   wire dlc_lane_t act_code = lane_code(lst_ff, hs_bit, mark_bit);

   always_comb
   begin
      nxt_lst = lst_ff;
      nxt_cnt = cnt_ff;
      unique case (lst_ff)
         L_STOP:
            if (req_s2_ff)
            begin
               nxt_cnt = DLC_CNT_RST;
               if (cmd_ff.op == DLC_OP_HS) nxt_lst = L_SOT01;
               else if (cmd_ff.op == DLC_OP_ESC) nxt_lst = L_E10;
               else nxt_lst = L_TA01;
            end
         L_SOT01: nxt_lst = L_SOT00;
         L_SOT00: nxt_lst = L_LEAD;
         L_LEAD:
         begin
            nxt_cnt = cnt_ff + 8'h01;
            if (cnt_ff == 8'(DLC_LEAD_BITS - 1))
            begin
               nxt_cnt = DLC_CNT_RST;
               nxt_lst = (lcmd_ff.len == DLC_CNT_RST) ? L_EOT00 : L_PAY;
            end
         end
         L_PAY:
         begin
            nxt_cnt = cnt_ff + 8'h01;
            if (nxt_cnt == lcmd_ff.len) nxt_lst = L_EOT00;
         end
         L_EOT00: nxt_lst = L_EOT10;
         L_EOT10: nxt_lst = L_DONE;
         L_TA01:  nxt_lst = L_TA00;
         L_TA00:  nxt_lst = L_TAHS0;
         L_TAHS0: nxt_lst = L_DONE;
         L_E10:   nxt_lst = L_E00A;
         L_E00A:  nxt_lst = L_E01;
         L_E01:   nxt_lst = L_E00B;
         L_E00B:  nxt_lst = L_EMARK;
         L_EMARK: nxt_lst = L_ESPACE;
         L_ESPACE:
         begin
            nxt_cnt = cnt_ff + 8'h01;
            nxt_lst = ({1'b0, nxt_cnt} == esc_bits) ? L_EX10 : L_EMARK;
         end
         L_EX10:  nxt_lst = L_DONE;
         L_DONE:
            if (!req_s2_ff) nxt_lst = L_STOP;
         default: nxt_lst = L_STOP;
      endcase
   end

   // state, request sync, command capture
   always_ff @(posedge clk_link or negedge reset_n)
   begin
      if (!reset_n)
      begin
         lst_ff    <= L_STOP;
         cnt_ff    <= DLC_CNT_RST;
         req_s1_ff <= 1'b0;
         req_s2_ff <= 1'b0;
         ack_ff    <= 1'b0;
         lcmd_ff   <= '0;
      end
      else
      begin
         lst_ff    <= nxt_lst;
         cnt_ff    <= nxt_cnt;
         req_s1_ff <= req_ff;
         req_s2_ff <= req_s1_ff;
         ack_ff    <= (nxt_lst == L_DONE);
         if (start)
            lcmd_ff <= cmd_ff;
      end
   end

   // one code for all lanes keeps them in step; disabled lanes sit in stop
   always_ff @(posedge clk_link or negedge reset_n)
   begin
      if (!reset_n)
      begin
         dlane_ff <= {DLC_LANES{DLC_LP11}};
         clane_ff <= DLC_LP11;
         ddr_ff   <= 1'b0;
      end
      else
      begin
         for (int i = 0; i < DLC_LANES; i++)
            dlane_ff[i] <= lcmd_ff.lane_on[i] ? act_code : DLC_LP11;
         ddr_ff   <= act_code.hs & ~ddr_ff;
         clane_ff <= act_code.hs ? '{hs: 1'b1, dp: ddr_ff, dn: ~ddr_ff} : DLC_LP11;
      end
   end

   assign data_lane   = dlane_ff;
   assign clock_lane  = clane_ff;
   assign link_bit_rd = (lst_ff == L_PAY) | ((lst_ff == L_EMARK) & ~in_cmd);

   // ---------------- checks ----------------
   lane_zero_on_a: assert property (@(posedge clk_link) disable iff (!reset_n)
      start |=> lcmd_ff.lane_on[0])
      else $error("lane zero not enabled");

   nv_window_a: assert property (@(posedge clk_sys) disable iff (!reset_n)
      nv_taken && !burst_mode |-> $past(vblank))
      else $error("non-video outside vertical blanking");

   nv_lp_a: assert property (@(posedge clk_sys) disable iff (!reset_n)
      nv_taken && $past(nonvideo_lowpower_select) |-> cmd_ff.op == DLC_OP_ESC && cmd_ff.esc_cmd == DLC_ESC_LPDT)
      else $error("lp non-video not sent as escape data");

   hs_fill_a: assert property (@(posedge clk_sys) disable iff (!reset_n)
      dt_ff == DLC_DT_BLANK && $changed(dt_ff) |-> $past(hs_fill))
      else $error("blanking packet sent while lp blanking chosen");

   sot_seq_a: assert property (@(posedge clk_link) disable iff (!reset_n)
      lst_ff == L_SOT01 |=> lst_ff == L_SOT00 ##1 lst_ff == L_LEAD [*6])
      else $error("start of transmission order broken");

   eot_seq_a: assert property (@(posedge clk_link) disable iff (!reset_n)
      lst_ff == L_EOT00 |=> lst_ff == L_EOT10 ##1 act_code == DLC_LP11)
      else $error("end of transmission order broken");

   ta_seq_a: assert property (@(posedge clk_link) disable iff (!reset_n)
      lst_ff == L_TA01 |=> act_code == '{1'b0, 1'b0, 1'b0} ##1 act_code.hs && !act_code.dp ##1 act_code == DLC_LP11)
      else $error("turnaround order broken");

   esc_entry_a: assert property (@(posedge clk_link) disable iff (!reset_n)
      lst_ff == L_E10 |=> lst_ff == L_E00A ##1 lst_ff == L_E01 ##1 lst_ff == L_E00B ##1 lst_ff == L_EMARK)
      else $error("escape entry order broken");

   clk_hs_a: assert property (@(posedge clk_link) disable iff (!reset_n)
      lst_ff == L_PAY |=> clane_ff.hs)
      else $error("clock lane not in hs during burst");

   lanes_step_a: assert property (@(posedge clk_link) disable iff (!reset_n)
      lcmd_ff.lane_on[1] |=> data_lane[1] == data_lane[0])
      else $error("enabled lanes out of step");

   off_stop_a: assert property (@(posedge clk_link) disable iff (!reset_n)
      !lcmd_ff.lane_on[3] |=> data_lane[3] == DLC_LP11)
      else $error("disabled lane left stop");

   cov_hs_c:  cover property (@(posedge clk_link) disable iff (!reset_n) lst_ff == L_PAY);
   cov_esc_c: cover property (@(posedge clk_link) disable iff (!reset_n) lst_ff == L_EX10);
   cov_ta_c:  cover property (@(posedge clk_link) disable iff (!reset_n) lst_ff == L_TAHS0);
   cov_nv_c:  cover property (@(posedge clk_sys) disable iff (!reset_n) nv_taken && burst_mode && hblank);
endmodule
`default_nettype wire

//--- testbench/dlc_panel_model.sv
`timescale 1ns/1ps
`default_nettype none
module dlc_panel_model
   import dlc_pkg::*;
(
   input  wire logic      clk_link,
   input  wire logic      reset_n,
   input  wire dlc_lane_t clock_lane,
   input  wire dlc_lane_t lane,
   output logic [15:0]    ev_cnt,
   output logic [1:0]     ev_kind,
   output logic [7:0]     ev_cmd,
   output logic [7:0]     ev_bits,
   output logic [31:0]    ev_data,
   output logic           ev_ok
);
   localparam dlc_lane_t LP00 = '{hs: 1'b0, dp: 1'b0, dn: 1'b0};
   localparam dlc_lane_t LP01 = '{hs: 1'b0, dp: 1'b0, dn: 1'b1};
   localparam dlc_lane_t LP10 = '{hs: 1'b0, dp: 1'b1, dn: 1'b0};
   dlc_lane_t q[$];
   dlc_lane_t prv;
   logic      ok;

   // classify one excursion from stop: 0 hs burst, 1 escape, 2 turnaround, 3 malformed
   task automatic decode();
      int         i;
      int         n;
      logic [5:0] ld;
      {ev_kind, ev_cmd, ev_bits, ev_data, ld} = {2'h3, 8'h00, 8'h00, 32'h0, 6'h00};
      n = 0;
      if (q.size() > 2 && q[0] == LP01 && q[1] == LP00)
      begin
         for (i = 2; i < q.size() && q[i].hs; i++)
            if (i < 8) ld = {ld[4:0], q[i].dp};
            else {ev_data, ev_bits} = {ev_data[30:0], q[i].dp, ev_bits + 8'h01};
         if (i == 3 && q.size() == 3 && !q[2].dp) ev_kind = 2'h2;
         else if (i > 7 && ld == 6'h1D && q.size() == i + 2 && q[i] == LP00 && q[i+1] == LP10) ev_kind = 2'h0;
      end
      else if (q.size() > 4 && q[0] == LP10 && q[1] == LP00 && q[2] == LP01 && q[3] == LP00)
      begin
         // spaced one-hot: each mark is followed by a space, so stop can only mean exit
         for (i = 4; i + 1 < q.size() && q[i+1] == LP00 && q[i] != LP00; i += 2)
         begin
            if (n < 8) ev_cmd = {ev_cmd[6:0], q[i] == LP10};
            else {ev_data, ev_bits} = {ev_data[30:0], q[i] == LP10, ev_bits + 8'h01};
            n++;
         end
         if (n >= 8 && i == q.size() - 1 && q[i] == LP10) ev_kind = 2'h1;
      end
   endtask

   // sample mid link cycle, where the design's line flops have settled
   always @(negedge clk_link or negedge reset_n)
   begin
      if (!reset_n)
      begin
         q.delete();
         {ev_cnt, ev_ok, ok} = {16'h0000, 1'b1, 1'b1};
      end
      else
      begin
         if (clock_lane.hs !== lane.hs || (lane.hs && lane.dp === lane.dn)) ok = 1'b0;
         if (clock_lane.hs && prv.hs && clock_lane.dp === prv.dp) ok = 1'b0;
         if (lane != DLC_LP11) q.push_back(lane);
         else if (q.size() > 0)
         begin
            decode();
            {ev_ok, ok} = {ok, 1'b1};
            ev_cnt = ev_cnt + 16'h0001;
            q.delete();
         end
      end
      prv = clock_lane;
   end
endmodule
`default_nettype wire

//--- testbench/dlc_top_bench.sv
`timescale 1ns/1ps
`default_nettype none
module dlc_top_bench
   import dlc_pkg::*;
;
   logic            clk_sys = 1'b0, clk_link = 1'b0, reset_n = 1'b0;
   logic [1:0]      lane_count_select, virtual_channel_reg, pkt_vc, ev_kind;
   logic            nonvideo_lowpower_select, blanking_lowpower_select, burst_mode, hblank, vblank;
   logic            vid_valid, nv_valid, nv_dcs, esc_valid, ta_valid, link_tx_bit, link_bit_rd;
   logic            vid_taken, nv_taken, esc_taken, ta_taken, busy, ev_ok;
   logic [7:0]      vid_len, nv_len, ev_cmd, ev_bits;
   logic [5:0]      pkt_dt;
   logic [15:0]     ev_cnt;
   logic [31:0]     ev_data, sent;
   dlc_esc_e        esc_sel;
   dlc_lane_t       clock_lane;
   dlc_lane_t [3:0] data_lane;
   int              fails = 0, comparisons = 0, cycles = 0, lanes = 0, sent_n;
   logic [7:0]      codes [4] = '{8'h1E, 8'h62, 8'h5D, 8'h21};

   dlc_top dut (.clk_sys, .reset_n, .clk_link, .lane_count_select, .nonvideo_lowpower_select,
      .blanking_lowpower_select, .burst_mode, .virtual_channel_reg, .hblank, .vblank, .vid_valid,
      .vid_len, .nv_valid, .nv_dcs, .nv_len, .esc_valid, .esc_sel, .ta_valid, .link_tx_bit,
      .link_bit_rd, .vid_taken, .nv_taken, .esc_taken, .ta_taken, .pkt_dt, .pkt_vc, .busy,
      .clock_lane, .data_lane);
   dlc_panel_model panel (.clk_link, .reset_n, .clock_lane, .lane(data_lane[0]), .ev_cnt,
      .ev_kind, .ev_cmd, .ev_bits, .ev_data, .ev_ok);

   // clocks; link phase offset keeps its edges off the system edges
   always #5 clk_sys = ~clk_sys;
   initial
   begin
      #1.3;
      forever #62.5 clk_link = ~clk_link;
   end

   // payload source: random bit each link cycle, recorded when the design takes it
   always @(negedge clk_link) link_tx_bit <= 1'($urandom);
   always @(posedge clk_link) if (link_bit_rd === 1'b1) {sent, sent_n} <= {sent[30:0], link_tx_bit, sent_n + 1};

   // lanes above the selected count idle in stop, the rest mirror lane zero
   always @(negedge clk_link)
      if (reset_n === 1'b1)
         for (int i = 1; i < 4; i++)
            check("lane", data_lane[i], (i <= lanes) ? data_lane[0] : DLC_LP11);

   // hang guard, far above what the sequence needs
   always @(posedge clk_sys)
   begin
      cycles++;
      if (cycles == 30000)
      begin
         fails++;
         final_report();
      end
   end

   task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
      comparisons++;
      if (seen !== exp)
      begin
         fails++;
         $display("mismatch %s expected %0h seen %0h", what, exp, seen);
      end
   endtask

   task automatic final_report();
      if (fails == 0 && comparisons > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask

   // no job may start for n cycles
   task automatic quiet(input int n);
      int hits;
      hits = 0;
      repeat (n) @(negedge clk_sys) if (busy !== 1'b0) hits++;
      check("idle", hits, 0);
   endtask

   // one pending request gives one job, its tags and one matching lane excursion
   task automatic job(input int take, input logic [5:0] dt, input logic [1:0] kind, input logic [7:0] cmd,
                      input int bits);
      int w;
      int n;
      n = ev_cnt;
      {sent, sent_n} = '0;
      for (int i = 0; i < 300 && busy !== 1'b1; i++) @(negedge clk_sys);
      w = nv_taken === 1'b1 ? 0 : vid_taken === 1'b1 ? 1 : esc_taken === 1'b1 ? 2 : ta_taken === 1'b1 ? 3 : 9;
      {nv_valid, vid_valid, esc_valid, ta_valid} = 4'h0;
      if (take >= 0) check("taken", w, take);
      if (dt != 6'h00) check("pkt_dt", pkt_dt, dt);
      check("pkt_vc", pkt_vc, virtual_channel_reg);
      for (int i = 0; i < 3000 && ev_cnt == n; i++) @(negedge clk_sys);
      for (int i = 0; i < 300 && busy !== 1'b0; i++) @(negedge clk_sys);
      check("kind", ev_kind, kind);
      check("cmd", ev_cmd, cmd);
      check("bits", ev_bits, bits);
      check("taken bits", sent_n, bits);
      check("data", ev_data, sent);
      check("lines", ev_ok, 1'b1);
   endtask

   initial
   begin
      void'($urandom(32'hC473));
      {lane_count_select, virtual_channel_reg, nonvideo_lowpower_select, blanking_lowpower_select} = '0;
      {burst_mode, hblank, vblank, vid_valid, nv_valid, nv_dcs, esc_valid, ta_valid, link_tx_bit} = '0;
      {vid_len, nv_len} = '0;
      esc_sel = DLC_E_ULPS;
      // long enough for edges of both clocks under reset
      repeat (5) @(negedge clk_link);
      @(negedge clk_sys);
      check("reset", {busy, vid_taken, nv_taken, esc_taken, ta_taken, pkt_dt, pkt_vc}, 0);
      check("stop", {clock_lane, data_lane}, {5{DLC_LP11}});
      reset_n = 1'b1;
      @(negedge clk_sys);
      // lane count sweep, two bursts back to back each, empty ones first
      for (int lc = 0; lc < 4; lc++)
         repeat (2)
         begin
            lane_count_select = 2'(lc);
            lanes = lc;
            virtual_channel_reg = 2'($urandom);
            vid_len = (lc == 0) ? 8'h00 : 8'($urandom_range(24));
            vid_valid = 1'b1;
            job(1, 6'h3E, 2'h0, 8'h00, int'(vid_len));
         end
      // escape commands and turnaround in a low-power vertical blank
      {blanking_lowpower_select, vblank} = 2'h3;
      for (int s = 0; s < 4; s++)
      begin
         esc_sel = dlc_esc_e'(s);
         esc_valid = 1'b1;
         job(2, 6'h00, 2'h1, codes[s], 0);
      end
      ta_valid = 1'b1;
      job(3, 6'h00, 2'h2, 8'h00, 0);
      // non-burst: non-video waits out a horizontal blank, then goes in the vertical one
      {vblank, hblank, nv_dcs} = 3'h2;
      nv_len = 8'($urandom_range(24));
      nv_valid = 1'b1;
      quiet(60);
      {hblank, vblank, blanking_lowpower_select} = 3'h2;
      job(0, 6'h29, 2'h0, 8'h00, int'(nv_len));
      job(-1, 6'h19, 2'h0, 8'h00, int'(vid_len));
      quiet(60);
      // burst: non-video in a horizontal blank, then low power for the rest
      {vblank, hblank, burst_mode, nv_dcs} = 4'h7;
      nv_len = 8'($urandom_range(24));
      nv_valid = 1'b1;
      job(0, 6'h39, 2'h0, 8'h00, int'(nv_len));
      quiet(60);
      // low-power non-video leaves as escape data, whatever the burst setting
      for (int b = 0; b < 2; b++)
      begin
         {hblank, vblank, nonvideo_lowpower_select, burst_mode} = {3'h3, 1'(b)};
         nv_len = 8'($urandom_range(24));
         nv_valid = 1'b1;
         job(0, 6'h39, 2'h1, 8'hE1, int'(nv_len));
         quiet(40);
         vblank = 1'b0;
         repeat (3) @(negedge clk_sys);
      end
      final_report();
   end
endmodule
`default_nettype wire
